// ### rtl/adq_top.sv
/*
  Converter sequencer: APB registers, start delay, sampling and
  successive-approximation stepping, result store, conversion-end request.
  Assumes an external DAC/comparator pair and port pins asynchronous to MCLK_IN.
*/
`timescale 1ns/1ps
`default_nettype none
module adq_top (
  // Clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RESETN_IN,
  // APB slave
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Analog front end
  input  wire logic        COMP_IN,
  output logic      [2:0]  CHANNEL_OUT,
  output logic             SAMPLE_OUT,
  output logic             COMP_EN_OUT,
  output logic      [9:0]  DAC_OUT,
  // Shared port pins and interrupt
  input  wire logic [7:0]  PORT_PINS_IN,
  output logic             CONV_END_IRQ_OUT
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic       wr, rd_setup, mapped, wr_mode, wr_chan;
  logic [7:0] mode_q, mode_d, pft_q;
  logic [2:0] chan_q;
  logic [9:0] res_q, trial_q;
  logic [1:0] pfm_q;
  logic       flag_q, irq_q;
  logic       comp_s1_q, comp_s2_q;
  logic [7:0] port_s1_q, port_s2_q;
  assign wr       = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_setup = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  assign mapped   = (PADDR_IN <= adq_pkg::OFS_PORT) && (PADDR_IN[1:0] == 2'h0);
  assign wr_mode  = wr && (PADDR_IN == adq_pkg::OFS_MODE);
  assign wr_chan  = wr && (PADDR_IN == adq_pkg::OFS_CHAN);
  assign mode_d   = wr_mode ? PWDATA_IN[7:0] : mode_q;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  adq_pkg::adq_state_t state_q;
  logic [8:0] dly_q, tot_q, step_q;
  logic [3:0] bit_q;
  logic [2:0] code;
  logic       run_ok, done, conflict, eoc, pf_pass;
  assign code     = mode_q[adq_pkg::MODE_CODE +: 3];
  // Prohibited codes have zero in the table and never run
  assign run_ok   = mode_d[adq_pkg::MODE_START] &&
                    (adq_pkg::T_TOTAL[mode_d[adq_pkg::MODE_CODE +: 3]] != 9'h000);
  assign done     = (state_q == adq_pkg::ST_CONVERT) &&
                    (tot_q == adq_pkg::T_TOTAL[code] - 9'h001);
  assign conflict = wr_mode | wr_chan;
  assign eoc      = done & ~conflict;
  // Upper result bits come straight from the finished trial word
  assign pf_pass  = ~pfm_q[1] ? 1'b1 :
                    (pfm_q[0] ? (trial_q[9:2] < pft_q) : (trial_q[9:2] >= pft_q));

  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      state_q <= adq_pkg::ST_IDLE;
      dly_q   <= 9'h000;
      tot_q   <= 9'h000;
    end else if (!run_ok) begin
      state_q <= adq_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        adq_pkg::ST_IDLE: begin
          state_q <= adq_pkg::ST_DELAY;
          dly_q   <= 9'h000;
        end
        adq_pkg::ST_DELAY: begin
          dly_q <= dly_q + 9'h001;
          if (dly_q == adq_pkg::T_DELAY[code] - 9'h001) begin
            state_q <= adq_pkg::ST_SAMPLE;
            tot_q   <= 9'h000;
          end
        end
        adq_pkg::ST_SAMPLE, adq_pkg::ST_CONVERT: begin
          tot_q <= tot_q + 9'h001;
          // A mode or channel write restarts sampling on the new setting
          if (conflict || done) begin
            state_q <= adq_pkg::ST_SAMPLE;
            tot_q   <= 9'h000;
          end else if (state_q == adq_pkg::ST_SAMPLE &&
                       tot_q == adq_pkg::T_SAMPLE[code] - 9'h001) begin
            state_q <= adq_pkg::ST_CONVERT;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Successive approximation
  // ----------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      trial_q <= adq_pkg::SAR_MSB;
      step_q  <= 9'h000;
      bit_q   <= 4'h9;
    end else if (state_q != adq_pkg::ST_CONVERT) begin
      trial_q <= adq_pkg::SAR_MSB;
      step_q  <= 9'h000;
      bit_q   <= 4'h9;
    end else if (bit_q != 4'hF) begin
      // Steps are long enough to cover the two-stage comparator sync
      if (step_q == adq_pkg::T_STEP[code] - 9'h001) begin
        step_q          <= 9'h000;
        bit_q           <= bit_q - 4'h1;
        trial_q[bit_q]  <= comp_s2_q;
        if (bit_q != 4'h0) begin
          trial_q[bit_q - 4'h1] <= 1'b1;
        end
      end else begin
        step_q <= step_q + 9'h001;
      end
    end
  end

  // ----------------------------------------
  // Result, flag and request
  // ----------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      res_q <= 10'h000;
      irq_q <= 1'b0;
    end else begin
      irq_q <= eoc & pf_pass;
      if (eoc) begin
        res_q <= trial_q;
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      flag_q <= 1'b0;
    end else if (eoc & pf_pass) begin
      flag_q <= 1'b1;
    end else if (wr && PADDR_IN == adq_pkg::OFS_STAT && PWDATA_IN[adq_pkg::STAT_FLAG]) begin
      // Only the status write clears it; a channel write leaves it alone
      flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      mode_q <= adq_pkg::MODE_RST;
      chan_q <= 3'h0;
      pfm_q  <= 2'h0;
      pft_q  <= adq_pkg::PFT_RST;
    end else begin
      mode_q <= mode_d;
      if (wr_chan) begin
        chan_q <= PWDATA_IN[2:0];
      end
      if (wr && PADDR_IN == adq_pkg::OFS_PFM) begin
        pfm_q <= {PWDATA_IN[adq_pkg::PFM_EN], PWDATA_IN[adq_pkg::PFM_COND]};
      end
      if (wr && PADDR_IN == adq_pkg::OFS_PFT) begin
        pft_q <= PWDATA_IN[7:0];
      end
    end
  end

  // Read data is latched in the setup cycle, so a result stored during
  // the access cycle lands after the read has its old value
  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (PADDR_IN)
        adq_pkg::OFS_MODE: PRDATA_OUT <= {24'h00_0000, mode_q};
        adq_pkg::OFS_CHAN: PRDATA_OUT <= {29'h0000_0000, chan_q};
        adq_pkg::OFS_RES:  PRDATA_OUT <= {22'h00_0000, res_q};
        adq_pkg::OFS_PFM:  PRDATA_OUT <= {24'h00_0000, pfm_q, 6'h00};
        adq_pkg::OFS_PFT:  PRDATA_OUT <= {24'h00_0000, pft_q};
        adq_pkg::OFS_STAT: PRDATA_OUT <= {30'h0000_0000, state_q != adq_pkg::ST_IDLE, flag_q};
        adq_pkg::OFS_PORT: PRDATA_OUT <= {24'h00_0000, port_s2_q};
        default:           PRDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
      port_s1_q <= 8'h00;
      port_s2_q <= 8'h00;
    end else begin
      comp_s1_q <= COMP_IN;
      comp_s2_q <= comp_s1_q;
      port_s1_q <= PORT_PINS_IN;
      port_s2_q <= port_s1_q;
    end
  end

  assign CHANNEL_OUT      = chan_q;
  assign SAMPLE_OUT       = (state_q == adq_pkg::ST_SAMPLE);
  assign COMP_EN_OUT      = mode_q[adq_pkg::MODE_CMP_EN];
  assign DAC_OUT          = trial_q;
  assign CONV_END_IRQ_OUT = irq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  read_old_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    rd_setup && PADDR_IN == adq_pkg::OFS_RES |=> PRDATA_OUT[9:0] == $past(res_q))
    else $error("result read did not return old value");
  write_wins_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    done && conflict |=> res_q == $past(res_q) && !CONV_END_IRQ_OUT)
    else $error("conflicting write did not drop result");
  flag_keep_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    flag_q && wr_chan |=> flag_q)
    else $error("channel write cleared flag");
  sample_len_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    state_q == adq_pkg::ST_SAMPLE ##1 state_q == adq_pkg::ST_CONVERT
    |-> $past(tot_q) == adq_pkg::T_SAMPLE[code] - 9'h001)
    else $error("sampling length wrong");
  delay_len_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    state_q == adq_pkg::ST_DELAY ##1 state_q == adq_pkg::ST_SAMPLE
    |-> $past(dly_q) == adq_pkg::T_DELAY[code] - 9'h001)
    else $error("start delay length wrong");
  bad_code_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    !run_ok |=> state_q == adq_pkg::ST_IDLE)
    else $error("sequencer ran on prohibited code or stopped start");
  irq_store_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    eoc && pf_pass |=> CONV_END_IRQ_OUT && flag_q && res_q == $past(trial_q) ##1 !CONV_END_IRQ_OUT)
    else $error("conversion end not stored or pulse too long");
  abort_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    wr_mode && !PWDATA_IN[adq_pkg::MODE_START] |=> !CONV_END_IRQ_OUT && res_q == $past(res_q))
    else $error("abort produced a result");
  pf_gate_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    CONV_END_IRQ_OUT && pfm_q == 2'h2 |-> res_q[9:2] >= pft_q)
    else $error("power-fail gate let a low result through");

  // ----------------------------------------
  // Sequencing and register checks
  // ----------------------------------------
  start_delay_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    state_q == adq_pkg::ST_IDLE && run_ok |=> state_q == adq_pkg::ST_DELAY && dly_q == 9'h000)
    else $error("start did not enter the start delay");
  start_bit_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    wr_mode && !PWDATA_IN[adq_pkg::MODE_START] |=> state_q == adq_pkg::ST_IDLE)
    else $error("cleared start bit left sequencer running");
  chan_follow_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    wr_chan |=> CHANNEL_OUT == $past(PWDATA_IN[2:0]))
    else $error("channel output does not follow channel write");
  code_field_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    wr_mode |=> code == $past(PWDATA_IN[adq_pkg::MODE_CODE +: 3]))
    else $error("time code not taken from mode write");
  comp_enable_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    wr_mode |=> COMP_EN_OUT == $past(PWDATA_IN[adq_pkg::MODE_CMP_EN]))
    else $error("comparator enable not taken from mode write");
  total_len_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    state_q == adq_pkg::ST_CONVERT |-> tot_q < adq_pkg::T_TOTAL[code])
    else $error("conversion ran past its total time");
  sample_window_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    SAMPLE_OUT |-> tot_q < adq_pkg::T_SAMPLE[code])
    else $error("sampling switch closed too long");
  sar_done_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    done |-> bit_q == 4'hF)
    else $error("conversion ended before all bits decided");
  result_hold_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    !eoc |=> res_q == $past(res_q))
    else $error("result changed without a conversion end");
  result_store_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    eoc |=> res_q == $past(trial_q))
    else $error("finished conversion not stored");
  irq_cause_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    CONV_END_IRQ_OUT |-> $past(eoc))
    else $error("request without an accepted conversion end");
  pf_below_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    CONV_END_IRQ_OUT && pfm_q == 2'h3 |-> res_q[9:2] < pft_q)
    else $error("power-fail gate let a high result through");
  flag_clear_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    wr && PADDR_IN == adq_pkg::OFS_STAT && PWDATA_IN[adq_pkg::STAT_FLAG] && !(eoc && pf_pass) |=> !flag_q)
    else $error("status write did not clear flag");
  port_read_a: assert property (@(posedge MCLK_IN) disable iff (!RESETN_IN)
    rd_setup && PADDR_IN == adq_pkg::OFS_PORT |=> PRDATA_OUT[7:0] == $past(port_s2_q))
    else $error("port read did not return pin levels");
endmodule // adq_top
`default_nettype wire

// ### pkg/adq_pkg.sv
/*
  Constants, register map and timing tables of the converter sequencer.
  Assumes a 32-bit APB slave with byte addresses in the low 8 bits.
*/
`default_nettype none
package adq_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CHAN = 8'h04;
  localparam logic [7:0] OFS_RES  = 8'h08;
  localparam logic [7:0] OFS_PFM  = 8'h0C;
  localparam logic [7:0] OFS_PFT  = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_PORT = 8'h18;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int MODE_CMP_EN = 0;
  localparam int MODE_CODE   = 3;
  localparam int MODE_START  = 7;
  localparam int PFM_COND    = 6;
  localparam int PFM_EN      = 7;
  localparam int STAT_FLAG   = 0;
  localparam int STAT_BUSY   = 1;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PFT_RST  = 8'h00;
  localparam logic [9:0] SAR_MSB  = 10'h200;
  // ----------------------------------------
  // Timing tables in main clocks, indexed by time code (7 down to 0)
  // ----------------------------------------
  localparam logic [7:0][8:0] T_TOTAL  = {9'h000, 9'h060, 9'h078, 9'h090,
                                          9'h000, 9'h0C0, 9'h0F0, 9'h120};
  localparam logic [7:0][8:0] T_SAMPLE = {9'h000, 9'h00C, 9'h010, 9'h014,
                                          9'h000, 9'h018, 9'h020, 9'h028};
  localparam logic [7:0][8:0] T_DELAY  = {9'h000, 9'h00C, 9'h00E, 9'h010,
                                          9'h000, 9'h018, 9'h01C, 9'h020};
  localparam logic [7:0][8:0] T_STEP   = {9'h000, 9'h008, 9'h00A, 9'h00C,
                                          9'h000, 9'h010, 9'h014, 9'h018};
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONVERT} adq_state_t;
endpackage
`default_nettype wire

// ### tb/adq_analog_model.sv
/*
  Behavioural analog front end: eight input levels, sample-and-hold, comparator.
  Assumes the sequencer drives channel, sampling switch, enable and trial word.
*/
`timescale 1ns/1ps
`default_nettype none
module adq_analog_model (
  // Sequencer side
  input  wire logic            clk_in,
  input  wire logic [2:0]      channel_in,
  input  wire logic            sample_in,
  input  wire logic            comp_en_in,
  input  wire logic [9:0]      dac_in,
  // Pin levels and decisions
  input  wire logic [7:0][9:0] level_in,
  output logic                 comp_out,
  output logic      [7:0]      port_out
);
  logic [9:0] held_q = 10'h000;
  logic       last_q = 1'b0;
  // Capacitor tracks the selected input only while the switch is closed
  always_ff @(posedge clk_in) begin
    if (sample_in) begin
      held_q <= level_in[channel_in];
    end
    last_q <= comp_out;
  end
  // A disabled comparator decides nothing useful, so it toggles every cycle
  always_comb begin
    comp_out = comp_en_in ? (held_q >= dac_in) : ~last_q;
    for (int i = 0; i < 8; i++) begin
      port_out[i] = level_in[i][9];
    end
  end
endmodule // adq_analog_model
`default_nettype wire

// ### tb/tb.sv
/*
  Self-checking bench of the converter sequencer: APB master, timing and conflict cases.
  Assumes the zero-wait APB slave of adq_top and the analog model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic            clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic            comp, pready, pslverr, sample, comp_en, irq, err;
  logic [7:0]      paddr = 8'h00, port;
  logic [31:0]     pwdata = 32'h0000_0000, prdata, rd;
  logic [2:0]      chan;
  logic [9:0]      dac;
  logic [7:0][9:0] level;
  logic [31:0]     seed = 32'h0000_005D;
  int              fail_count = 0, check_count = 0, scnt = 0, icnt = 0;

  // The main clock never stops, so every register access below is legal
  always #25 clk = ~clk;
  always @(posedge clk) begin
    scnt <= scnt + int'(sample === 1'b1);
    icnt <= icnt + int'(irq === 1'b1);
  end

  adq_top adq_top_i (.MCLK_IN(clk), .RESETN_IN(rst_n), .PADDR_IN(paddr), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .COMP_IN(comp), .CHANNEL_OUT(chan),
    .SAMPLE_OUT(sample), .COMP_EN_OUT(comp_en), .DAC_OUT(dac), .PORT_PINS_IN(port),
    .CONV_END_IRQ_OUT(irq));
  adq_analog_model adq_analog_model_i (.clk_in(clk), .channel_in(chan), .sample_in(sample),
    .comp_en_in(comp_en), .dac_in(dac), .level_in(level), .comp_out(comp), .port_out(port));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic pf_irq(logic [9:0] res, logic [7:0] powerfail_mode_reg, logic [7:0] thr);
    if (!powerfail_mode_reg[adq_pkg::PFM_EN]) return 1'b1;
    return powerfail_mode_reg[adq_pkg::PFM_COND] ? (res[9:2] < thr) : (res[9:2] >= thr);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // ----------------------------------------
  // APB master: called just after a rising edge, returns one edge after release
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end

  initial begin
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    logic [2:0] c, ch;
    logic [7:0] powerfail_mode_reg, thr;
    int         s0, i0;
    for (int i = 0; i < 8; i++) level[i] = 10'(xs());
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, adq_pkg::OFS_MODE, 32'h0000_0000);
    check(rd, {24'h00_0000, adq_pkg::MODE_RST}, "mode reset");
    apb(1'b0, adq_pkg::OFS_PFT, 32'h0000_0000);
    check(rd, {24'h00_0000, adq_pkg::PFT_RST}, "threshold reset");
    apb(1'b0, 8'h1C, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001, "unmapped error");
    apb(1'b0, adq_pkg::OFS_PORT, 32'h0000_0000);
    check(rd, {24'h00_0000, port}, "port pins");
    apb(1'b1, adq_pkg::OFS_MODE, 32'h0000_0001);
    repeat (300) @(posedge clk);
    for (int k = 0; k < 6; k++) begin
      c = codes[k];
      ch = 3'(xs());
      powerfail_mode_reg = (k == 5) ? 8'h00 : {2'(xs()), 6'h00};
      thr = 8'(xs());
      apb(1'b1, adq_pkg::OFS_CHAN, {29'h0, ch});
      apb(1'b1, adq_pkg::OFS_PFM, {24'h00_0000, powerfail_mode_reg});
      apb(1'b1, adq_pkg::OFS_PFT, {24'h00_0000, thr});
      apb(1'b1, adq_pkg::OFS_STAT, 32'h0000_0001);
      apb(1'b1, adq_pkg::OFS_MODE, {24'h00_0000, 2'b10, c, 3'h1});
      s0 = scnt;
      i0 = icnt;
      repeat (int'(adq_pkg::T_DELAY[c]) + int'(adq_pkg::T_TOTAL[c]) - 1) @(posedge clk);
      // Look mid-cycle, where the one-cycle request stands settled
      @(negedge clk);
      check(32'(icnt - i0), 32'h0000_0000, "early request");
      check({31'h0, irq}, {31'h0, pf_irq(level[ch], powerfail_mode_reg, thr)}, "request");
      check(32'(scnt - s0), {23'h0, adq_pkg::T_SAMPLE[c]}, "sample span");
      @(posedge clk);
      apb(1'b0, adq_pkg::OFS_RES, 32'h0000_0000);
      check(rd, {22'h0, level[ch]}, "result");
      apb(1'b0, adq_pkg::OFS_STAT, 32'h0000_0000);
      check({31'h0, rd[adq_pkg::STAT_FLAG]}, {31'h0, pf_irq(level[ch], powerfail_mode_reg, thr)}, "flag");
      if (k < 5) apb(1'b1, adq_pkg::OFS_MODE, 32'h0000_0001);
    end
    // Channel rewrite mid-run, then a rewrite landing on the done edge
    apb(1'b1, adq_pkg::OFS_CHAN, {29'h0, ch + 3'h1});
    repeat (93) @(posedge clk);
    i0 = icnt;
    apb(1'b1, adq_pkg::OFS_CHAN, {29'h0, ch + 3'h2});
    apb(1'b0, adq_pkg::OFS_RES, 32'h0000_0000);
    check(rd, {22'h0, level[ch]}, "result after conflict");
    apb(1'b0, adq_pkg::OFS_STAT, 32'h0000_0000);
    check({31'h0, rd[adq_pkg::STAT_FLAG]}, 32'h0000_0001, "flag kept");
    check(32'(icnt - i0), 32'h0000_0000, "suppressed request");
    repeat (88) @(posedge clk);
    apb(1'b0, adq_pkg::OFS_RES, 32'h0000_0000);
    check(rd, {22'h0, level[ch]}, "read at done edge");
    check(32'(icnt - i0), 32'h0000_0001, "request after restart");
    apb(1'b0, adq_pkg::OFS_RES, 32'h0000_0000);
    check(rd, {22'h0, level[ch + 3'h2]}, "new channel result");
    // Abort a code 000 conversion on another channel well before it could end
    apb(1'b1, adq_pkg::OFS_MODE, 32'h0000_0081);
    apb(1'b1, adq_pkg::OFS_CHAN, {29'h0, ch + 3'h3});
    repeat (50 + int'(7'(xs()))) @(posedge clk);
    i0 = icnt;
    apb(1'b1, adq_pkg::OFS_MODE, 32'h0000_0001);
    repeat (400) @(posedge clk);
    check(32'(icnt - i0), 32'h0000_0000, "aborted request");
    apb(1'b0, adq_pkg::OFS_RES, 32'h0000_0000);
    check(rd, {22'h0, level[ch + 3'h2]}, "aborted result");
    // A prohibited time code with the start bit set must leave the sequencer idle
    i0 = icnt;
    apb(1'b1, adq_pkg::OFS_MODE, 32'h0000_0099);
    repeat (300) @(posedge clk);
    check(32'(icnt - i0), 32'h0000_0000, "prohibited code request");
    apb(1'b0, adq_pkg::OFS_STAT, 32'h0000_0000);
    check({31'h0, rd[adq_pkg::STAT_BUSY]}, 32'h0000_0000, "prohibited code busy");
    final_report();
  end
endmodule // tb
`default_nettype wire
